// file: dv/sdb_properties.sv
// Timing checks on the lines between controller and memory.
// Assumes one clock and the interface signals wired in by name.
`timescale 1ns/100ps
module sdb_properties (
  input wire logic                        clk_sys,
  input wire logic                        rst,
  input wire logic                        cs_n,
  input wire logic                        ras_n,
  input wire logic                        cas_n,
  input wire logic                        we_n,
  input wire logic [sdb_pkg::ADDR_W-1:0]  addr,
  input wire logic                        dqm,
  input wire logic                        dq_ctl_oe,
  input wire logic                        dq_dev_oe,
  input wire logic                        cfg_cl3,
  input wire logic [2:0]                  cfg_bl,
  input wire logic                        ap_start
);
  // ****************************************
  // Command decode and properties
  // ****************************************
  logic [2:0] cmd;
  logic       rd;
  logic       wr;
  logic       stop;
  logic       ap;

  assign cmd  = {ras_n, cas_n, we_n};
  assign rd   = !cs_n && cmd == sdb_pkg::CMD_READ;
  assign wr   = !cs_n && cmd == sdb_pkg::CMD_WRITE;
  assign stop = !cs_n && (cmd == sdb_pkg::CMD_BST || cmd == sdb_pkg::CMD_PRE);
  assign ap   = addr[sdb_pkg::AP_BIT];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_read_first_cl2: assert property (
    rd && !cfg_cl3 && !dqm |-> ##2 dq_dev_oe)
    else $error("read data late at latency two");
  a_read_first_cl3: assert property (
    rd && cfg_cl3 && !dqm |-> ##2 !dq_dev_oe ##1 dq_dev_oe)
    else $error("read data off time at latency three");
  a_single_read_ends: assert property (
    rd && !cfg_cl3 && !dqm && cfg_bl == sdb_pkg::BL_1 |->
    ##2 dq_dev_oe ##1 !dq_dev_oe)
    else $error("data lines not released after burst");
  a_mask_blocks_out: assert property (dqm |-> ##2 !dq_dev_oe)
    else $error("masked read element driven");
  a_write_floats_dq: assert property (wr |=> !dq_dev_oe)
    else $error("memory drives during write");
  a_no_bus_fight: assert property (!(dq_dev_oe && dq_ctl_oe))
    else $error("both ends drive data lines");
  a_write_unmasked: assert property (wr |-> dq_ctl_oe && !dqm)
    else $error("write data not presented unmasked");
  a_stop_ends_read: assert property (stop |-> ##3 !dq_dev_oe)
    else $error("read burst runs on after stop");
  a_ap_after_write: assert property (
    wr && ap && cfg_bl == sdb_pkg::BL_1 |=> !ap_start ##[0:3] ap_start)
    else $error("auto precharge timing after write");
  a_page_no_ap: assert property (
    (rd || wr) && cfg_bl == sdb_pkg::BL_PAGE |=> !ap_start [*6])
    else $error("auto precharge on page burst");

  c_read_cl3: cover property (rd && cfg_cl3);
  c_write_ap: cover property (wr && ap);
  c_stop_read: cover property (stop && dq_dev_oe);
  c_page_read: cover property (rd && cfg_bl == sdb_pkg::BL_PAGE);
endmodule

// file: dv/testbench.sv
// Drives the controller over Avalon-MM and reads back the memory end.
// Assumes both design ends meet through one sdb_link_if instance.
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    checked++; \
    if ((got) !== (ex)) \
    begin \
      err_count++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end \
  end
module testbench;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clk_sys       = 1'b0;
  logic        rst           = 1'b1;
  logic [4:0]  avs_address   = 5'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        cfg_cl3;
  logic [2:0]  cfg_bl;
  logic        ap_start;
  logic [1:0]  ap_bank;
  logic [31:0] rd;
  logic [15:0] wr_dq;
  logic [15:0] rd_dq;
  logic [15:0] base;
  logic [8:0]  col;
  logic [8:0]  c;
  int          err_count = 0;
  int          checked   = 0;
  int          ap_cnt    = 0;
  int          k;
  int          n;

  sdb_link_if link ();

  always #50 clk_sys = ~clk_sys;

  sdb_ctl i_sdb_ctl (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link), .cfg_cl3(cfg_cl3),
    .cfg_bl(cfg_bl));
  sdb_dev i_sdb_dev (.clk_sys(clk_sys), .rst(rst), .link(link),
    .cfg_cl3(cfg_cl3), .cfg_bl(cfg_bl), .ap_start(ap_start),
    .ap_bank(ap_bank));
  sdb_properties i_sdb_properties (.clk_sys(clk_sys), .rst(rst),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
    .we_n(link.we_n), .addr(link.addr), .dqm(link.dqm),
    .dq_ctl_oe(link.dq_ctl_oe), .dq_dev_oe(link.dq_dev_oe),
    .cfg_cl3(cfg_cl3), .cfg_bl(cfg_bl), .ap_start(ap_start));

  // The wire is sampled at the WRITE edge, where the first element lands.
  always @(posedge clk_sys)
  begin
    if ({link.ras_n, link.cas_n, link.we_n} === sdb_pkg::CMD_WRITE)
      wr_dq <= link.dq;
    // The last read element the memory drove, for the page wrap check.
    if (link.dq_dev_oe === 1'b1)
      rd_dq <= link.dq;
    if (ap_start === 1'b1)
      ap_cnt <= ap_cnt + 1;
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic timeout();
    err_count++;
    $display("CHECK FAILED wait exp done got none");
    summarize();
  endtask

  task automatic av_req(input logic [4:0] a, input logic w,
                        input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (avs_waitrequest !== 1'b0 && i < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0)
      timeout();
  endtask

  // Waits for idle because a command sent while busy is dropped.
  task automatic run_cmd(input logic [1:0] op, input logic [1:0] bank,
                         input logic [8:0] cl, input logic ap);
    int i;
    av_req(sdb_pkg::REG_CMD, 1'b1, {15'h0, ap, 3'h0, cl, bank, op});
    i = 0;
    do
    begin
      av_req(sdb_pkg::REG_STATUS, 1'b0, 32'h0);
      i++;
    end
    while (rd[2:0] !== 3'h0 && i < 50);
    if (rd[2:0] !== 3'h0)
      timeout();
  endtask

  task automatic set_cfg(input logic cl3, input logic [2:0] bl);
    av_req(sdb_pkg::REG_CFG, 1'b1, {28'h0, bl, cl3});
  endtask

  task automatic read_col(input logic [1:0] bank, input logic [8:0] cl);
    run_cmd(sdb_pkg::OP_READ, bank, cl, 1'b0);
    av_req(sdb_pkg::REG_RDATA, 1'b0, 32'h0);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    av_req(sdb_pkg::REG_CFG, 1'b0, 32'h0);
    `CHK("cfg", {28'h0, sdb_pkg::CFG_RESET}, rd)
    av_req(5'h14, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("test reset done");
    for (int b = 0; b < 4; b++)
    begin
      n = 1 << b;
      col = 9'(b * 32 + 3);
      base = 16'h2000 + 16'(b * 256);
      set_cfg(b[0], 3'(b));
      av_req(sdb_pkg::REG_WDATA, 1'b1, {16'h0, base});
      run_cmd(sdb_pkg::OP_WRITE, 2'(b), col, 1'b0);
      `CHK("wr_dq", base, wr_dq)
      set_cfg(b[1], sdb_pkg::BL_1);
      for (int i = 0; i < n; i++)
      begin
        c = (col & ~9'(n - 1)) | ((col + 9'(i)) & 9'(n - 1));
        read_col(2'(b), c);
        `CHK("rdata", {16'h0, base + 16'(i)}, rd)
      end
      set_cfg(!b[0], 3'(b));
      read_col(2'(b), col);
      `CHK("rdata_last", {16'h0, base + 16'(n - 1)}, rd)
      $display("test burst code %0d done", b);
    end
    set_cfg(1'b0, sdb_pkg::BL_2);
    av_req(sdb_pkg::REG_WDATA, 1'b1, 32'h5a01);
    run_cmd(sdb_pkg::OP_WRITE, 2'h0, 9'h000, 1'b0);
    set_cfg(1'b0, sdb_pkg::BL_PAGE);
    av_req(sdb_pkg::REG_WDATA, 1'b1, 32'h5a00);
    run_cmd(sdb_pkg::OP_WRITE, 2'h0, 9'h1ff, 1'b0);
    run_cmd(sdb_pkg::OP_BST, 2'h0, 9'h0, 1'b0);
    set_cfg(1'b1, sdb_pkg::BL_1);
    read_col(2'h0, 9'h1ff);
    `CHK("page_last", 32'h5a00, rd)
    read_col(2'h0, 9'h000);
    `CHK("page_wrap", 32'h5a01, rd)
    set_cfg(1'b0, sdb_pkg::BL_PAGE);
    read_col(2'h0, 9'h1ff);
    `CHK("page_read", 32'h5a00, rd)
    `CHK("page_wrap_dq", 16'h5a02, rd_dq)
    run_cmd(sdb_pkg::OP_PRE, 2'h0, 9'h0, 1'b0);
    $display("test page done");
    set_cfg(1'b0, sdb_pkg::BL_1);
    k = ap_cnt;
    run_cmd(sdb_pkg::OP_WRITE, 2'h2, 9'h040, 1'b1);
    repeat (4) @(posedge clk_sys);
    `CHK("ap_cnt", k + 1, ap_cnt)
    `CHK("ap_bank", 2'h2, ap_bank)
    read_col(2'h1, 9'h040);
    run_cmd(sdb_pkg::OP_READ, 2'h1, 9'h040, 1'b1);
    repeat (4) @(posedge clk_sys);
    `CHK("ap_cnt", k + 2, ap_cnt)
    `CHK("ap_bank", 2'h1, ap_bank)
    run_cmd(sdb_pkg::OP_WRITE, 2'h3, 9'h041, 1'b0);
    repeat (4) @(posedge clk_sys);
    `CHK("ap_cnt", k + 2, ap_cnt)
    $display("test auto precharge done");
    summarize();
  end
endmodule

// file: rtl/sdb_ctl.sv
// Controller end: software orders one command at a time via Avalon-MM.
// Assumes the memory shares clk_sys; data lines are combined outside.
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/100ps
module sdb_ctl (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic [4:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest,
  sdb_link_if.ctl                         link,
  output logic                            cfg_cl3,
  output logic [2:0]                      cfg_bl
);
  localparam int DW = sdb_pkg::DATA_W;

  typedef enum logic [2:0] {
    SDC_IDLE  = 3'b000,
    SDC_MASK  = 3'b001,
    SDC_ISSUE = 3'b010,
    SDC_BURST = 3'b011,
    SDC_RECOV = 3'b100
  } sdc_state_t;

  sdc_state_t     st_ff;
  logic           wait_ff;
  logic [31:0]    rdata_bus_ff;
  logic [3:0]     cfg_ff;
  logic [DW-1:0]  wdata_ff;
  logic [DW-1:0]  rdata_ff;
  logic [31:0]    ord_ff;
  logic [12:0]    cnt_ff;
  logic [12:0]    cap_ff;
  logic [2:0]     cmd_ff;
  logic [1:0]     ba_ff;
  logic [11:0]    addr_ff;
  logic           dqm_ff;
  logic [DW-1:0]  dqo_ff;
  logic           dqoe_ff;

  logic           take;
  logic [1:0]     op;
  logic [12:0]    len;
  logic [12:0]    lat;

  assign take = (avs_read || avs_write) && !wait_ff;
  assign op   = ord_ff[sdb_pkg::CMD_OP_LSB +: 2];
  // A page burst is counted as one element; software stops it.
  assign len  = (cfg_ff[sdb_pkg::CFG_BL_LSB +: 3] == sdb_pkg::BL_PAGE)
                ? 13'h1
                : {1'b0, sdb_pkg::burst_mask(cfg_ff[3:1])} + 13'h1;
  assign lat  = cfg_ff[sdb_pkg::CFG_CL3_POS] ? 13'h3 : 13'h2;

  // ***************************************************************
  // Avalon slave: answer one cycle after the request appears
  // ***************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wait_ff      <= 1'b1;
      rdata_bus_ff <= '0;
      cfg_ff       <= sdb_pkg::CFG_RESET;
      wdata_ff     <= '0;
    end
    else
    begin
      wait_ff <= !((avs_read || avs_write) && wait_ff);
      if ((avs_read || avs_write) && wait_ff)
      begin
        case (avs_address)
          sdb_pkg::REG_CFG:    rdata_bus_ff <= {28'h0, cfg_ff};
          sdb_pkg::REG_WDATA:  rdata_bus_ff <= {16'h0, wdata_ff};
          sdb_pkg::REG_RDATA:  rdata_bus_ff <= {16'h0, rdata_ff};
          sdb_pkg::REG_STATUS: rdata_bus_ff <= {29'h0, st_ff};
          default:             rdata_bus_ff <= '0;
        endcase
      end
      if (take && avs_write && avs_address == sdb_pkg::REG_CFG)
        cfg_ff <= avs_writedata[3:0];
      if (take && avs_write && avs_address == sdb_pkg::REG_WDATA)
        wdata_ff <= avs_writedata[DW-1:0];
    end
  end

  // ***************************************************************
  // Command sequencer
  // ***************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_ff    <= SDC_IDLE;
      ord_ff   <= '0;
      cnt_ff   <= '0;
      cap_ff   <= '0;
      rdata_ff <= '0;
      cmd_ff   <= sdb_pkg::CMD_NOP;
      ba_ff    <= '0;
      addr_ff  <= '0;
      dqm_ff   <= 1'b1;
      dqo_ff   <= '0;
      dqoe_ff  <= 1'b0;
    end
    else
    begin
      cmd_ff <= sdb_pkg::CMD_NOP;
      case (st_ff)
        SDC_IDLE:
        begin
          if (take && avs_write && avs_address == sdb_pkg::REG_CMD)
          begin
            ord_ff <= avs_writedata;
            cnt_ff <= 13'h1;
            // Mask held three clocks before any WRITE.
            st_ff  <= (avs_writedata[1:0] == sdb_pkg::OP_WRITE)
                      ? SDC_MASK : SDC_ISSUE;
            dqm_ff <= 1'b1;
          end
        end
        SDC_MASK:
        begin
          cnt_ff <= cnt_ff - 13'h1;
          if (cnt_ff == 13'h0)
            st_ff <= SDC_ISSUE;
        end
        SDC_ISSUE:
        begin
          ba_ff   <= ord_ff[sdb_pkg::CMD_BANK_LSB +: 2];
          addr_ff <= {1'b0, ord_ff[sdb_pkg::CMD_AP_POS], 1'b0,
                      ord_ff[sdb_pkg::CMD_COL_LSB +: 9]};
          case (op)
            sdb_pkg::OP_READ:
            begin
              cmd_ff <= sdb_pkg::CMD_READ;
              dqm_ff <= 1'b0;
              cnt_ff <= lat + len - 13'h1;
              cap_ff <= len;
              st_ff  <= SDC_BURST;
            end
            sdb_pkg::OP_WRITE:
            begin
              cmd_ff  <= sdb_pkg::CMD_WRITE;
              dqm_ff  <= 1'b0;
              dqo_ff  <= wdata_ff;
              dqoe_ff <= 1'b1;
              cnt_ff  <= len - 13'h1;
              st_ff   <= SDC_BURST;
            end
            sdb_pkg::OP_PRE:
            begin
              cmd_ff <= sdb_pkg::CMD_PRE;
              cnt_ff <= 13'(sdb_pkg::TRP_CYC);
              st_ff  <= SDC_RECOV;
            end
            default:
            begin
              cmd_ff <= sdb_pkg::CMD_BST;
              cnt_ff <= 13'h0;
              st_ff  <= SDC_RECOV;
            end
          endcase
        end
        SDC_BURST:
        begin
          if (op == sdb_pkg::OP_WRITE)
          begin
            if (cnt_ff == 13'h0)
            begin
              dqoe_ff <= 1'b0;
              dqm_ff  <= 1'b1;
              cnt_ff  <= 13'(sdb_pkg::WR_CYC);
              st_ff   <= SDC_RECOV;
            end
            else
            begin
              dqo_ff <= dqo_ff + 1'b1;
              cnt_ff <= cnt_ff - 13'h1;
            end
          end
          else
          begin
            if (cnt_ff < cap_ff)
              rdata_ff <= link.dq;
            if (cnt_ff == 13'h0)
            begin
              dqm_ff <= 1'b1;
              st_ff  <= SDC_RECOV;
            end
            else
              cnt_ff <= cnt_ff - 13'h1;
          end
        end
        SDC_RECOV:
        begin
          if (cnt_ff == 13'h0)
            st_ff <= SDC_IDLE;
          else
            cnt_ff <= cnt_ff - 13'h1;
        end
        default: st_ff <= SDC_IDLE;
      endcase
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_bus_ff;
  assign link.cs_n       = 1'b0;
  assign {link.ras_n, link.cas_n, link.we_n} = cmd_ff;
  assign link.ba         = ba_ff;
  assign link.addr       = addr_ff;
  assign link.dqm        = dqm_ff;
  assign link.dq_ctl_o   = dqo_ff;
  assign link.dq_ctl_oe  = dqoe_ff;
  assign cfg_cl3         = cfg_ff[sdb_pkg::CFG_CL3_POS];
  assign cfg_bl          = cfg_ff[sdb_pkg::CFG_BL_LSB +: 3];
endmodule

// file: rtl/sdb_dev.sv
// Memory end: read and write burst engine with a small array.
// Assumes the controller keeps its timing and shares clk_sys.
`timescale 1ns/100ps
module sdb_dev #(
  parameter int WR_CYC = sdb_pkg::WR_CYC
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  sdb_link_if.dev                         link,
  input  wire logic                       cfg_cl3,
  input  wire logic [2:0]                 cfg_bl,
  output logic                            ap_start,
  output logic [sdb_pkg::BANK_W-1:0]      ap_bank
);
  localparam int CW = sdb_pkg::COL_W;
  localparam int BW = sdb_pkg::BANK_W;
  localparam int DW = sdb_pkg::DATA_W;

  typedef enum logic [1:0] {
    SDB_IDLE = 2'b00,
    SDB_RD   = 2'b01,
    SDB_WR   = 2'b10
  } sdb_burst_t;

  logic [DW-1:0]   mem [0:(1<<(BW+CW))-1];
  sdb_burst_t      act_ff;
  logic [CW-1:0]   col_ff;
  logic [BW-1:0]   bank_ff;
  logic [CW-1:0]   left_ff;
  logic            page_ff;
  logic            ap_ff;
  logic            p1_v_ff;
  logic            p2_v_ff;
  logic [DW-1:0]   p1_d_ff;
  logic [DW-1:0]   p2_d_ff;
  logic            dqm_d1_ff;
  logic            oe_ff;
  logic [DW-1:0]   dq_ff;
  logic            ap_pend_ff;
  logic [3:0]      ap_cnt_ff;
  logic            ap_start_ff;
  logic [BW-1:0]   ap_bank_ff;

  logic [2:0]      cmd;
  logic            is_rd;
  logic            is_wr;
  logic            is_bst;
  logic            pre_hit;
  logic            cont;
  logic            last;
  logic [CW-1:0]   mask;
  logic [CW-1:0]   cmd_col;
  logic [BW+CW-1:0] acc;
  logic            ends;

  // ***************************************************************
  // Command decode
  // ***************************************************************
  assign cmd     = link.cs_n ? sdb_pkg::CMD_NOP
                             : {link.ras_n, link.cas_n, link.we_n};
  assign is_rd   = (cmd == sdb_pkg::CMD_READ);
  assign is_wr   = (cmd == sdb_pkg::CMD_WRITE);
  assign is_bst  = (cmd == sdb_pkg::CMD_BST);
  assign pre_hit = (cmd == sdb_pkg::CMD_PRE) &&
                   (link.addr[sdb_pkg::AP_BIT] || link.ba == bank_ff);
  assign mask    = CW'(sdb_pkg::burst_mask(cfg_bl));
  assign cmd_col = link.addr[CW-1:0];
  // An element is due only while some remain and no new command cuts.
  assign cont    = (act_ff != SDB_IDLE) && !is_rd && !is_wr &&
                   !is_bst && !pre_hit &&
                   (page_ff || (left_ff != '0));
  // The cycle after the final element: the burst is over.
  assign last    = (act_ff != SDB_IDLE) && !is_rd && !is_wr &&
                   !is_bst && !pre_hit && !page_ff && (left_ff == '0);
  assign acc     = (is_rd || is_wr) ? {link.ba, cmd_col}
                                    : {bank_ff, col_ff};
  // End of an auto-precharge burst, finished or cut by a new READ or WRITE.
  assign ends    = ap_ff && (last || ((act_ff != SDB_IDLE) &&
                   (is_rd || is_wr)));

  function automatic logic [CW-1:0] step(input logic [CW-1:0] c,
                                        input logic [CW-1:0] m);
    // Wraps inside the block; a page burst wraps to column 0.
    step = (c & ~m) | ((c + 1'b1) & m);
  endfunction

  // ***************************************************************
  // Burst tracking
  // ***************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      act_ff  <= SDB_IDLE;
      col_ff  <= '0;
      bank_ff <= '0;
      left_ff <= '0;
      page_ff <= 1'b0;
      ap_ff   <= 1'b0;
    end
    else if (is_rd || is_wr)
    begin
      act_ff  <= is_rd ? SDB_RD : SDB_WR;
      col_ff  <= step(cmd_col, mask);
      bank_ff <= link.ba;
      left_ff <= mask;
      page_ff <= (cfg_bl == sdb_pkg::BL_PAGE);
      ap_ff   <= link.addr[sdb_pkg::AP_BIT] &&
                 (cfg_bl != sdb_pkg::BL_PAGE);
    end
    else if (!cont || last)
    begin
      act_ff <= SDB_IDLE;
      ap_ff  <= 1'b0;
    end
    else
    begin
      col_ff  <= step(col_ff, mask);
      left_ff <= left_ff - 1'b1;
    end
  end

  // ***************************************************************
  // Write capture: the element on the command edge belongs to it.
  // ***************************************************************
  always_ff @(posedge clk_sys)
  begin
    if ((is_wr || (cont && act_ff == SDB_WR)) && !link.dqm)
      mem[acc] <= link.dq;
  end

  // ***************************************************************
  // Read pipeline and output drive
  // ***************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      p1_v_ff   <= 1'b0;
      p2_v_ff   <= 1'b0;
      p1_d_ff   <= '0;
      p2_d_ff   <= '0;
      dqm_d1_ff <= 1'b0;
      oe_ff     <= 1'b0;
      dq_ff     <= '0;
    end
    else
    begin
      // A registered WRITE flushes pending read data.
      p1_v_ff   <= !is_wr && (is_rd || (cont && act_ff == SDB_RD));
      p2_v_ff   <= !is_wr && p1_v_ff;
      p1_d_ff   <= mem[acc];
      p2_d_ff   <= p1_d_ff;
      dqm_d1_ff <= link.dqm;
      dq_ff     <= cfg_cl3 ? p2_d_ff : p1_d_ff;
      oe_ff     <= !is_wr && !dqm_d1_ff &&
                   (cfg_cl3 ? p2_v_ff : p1_v_ff);
    end
  end

  // ***************************************************************
  // Auto precharge launch
  // ***************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ap_pend_ff  <= 1'b0;
      ap_cnt_ff   <= '0;
      ap_start_ff <= 1'b0;
      ap_bank_ff  <= '0;
    end
    else if (ends)
    begin
      ap_pend_ff  <= 1'b1;
      ap_bank_ff  <= bank_ff;
      // Writes wait out the recovery time before the row closes.
      ap_cnt_ff   <= (act_ff == SDB_WR) ? 4'(WR_CYC) : 4'h0;
      ap_start_ff <= 1'b0;
    end
    else
    begin
      ap_start_ff <= ap_pend_ff && (ap_cnt_ff == 4'h0);
      if (ap_pend_ff && ap_cnt_ff == 4'h0)
        ap_pend_ff <= 1'b0;
      else if (ap_cnt_ff != 4'h0)
        ap_cnt_ff <= ap_cnt_ff - 1'b1;
    end
  end

  assign link.dq_dev_o  = dq_ff;
  assign link.dq_dev_oe = oe_ff;
  assign ap_start       = ap_start_ff;
  assign ap_bank        = ap_bank_ff;
endmodule

// file: rtl/sdb_link_if.sv
// Command, address, mask and data lines between controller and memory.
// The shared data wire is resolved here from the two output enables.
`timescale 1ns/100ps
interface sdb_link_if;
  logic                            cs_n;
  logic                            ras_n;
  logic                            cas_n;
  logic                            we_n;
  logic [sdb_pkg::BANK_W-1:0]      ba;
  logic [sdb_pkg::ADDR_W-1:0]      addr;
  logic                            dqm;
  logic [sdb_pkg::DATA_W-1:0]      dq_ctl_o;
  logic                            dq_ctl_oe;
  logic [sdb_pkg::DATA_W-1:0]      dq_dev_o;
  logic                            dq_dev_oe;
  wire  [sdb_pkg::DATA_W-1:0]      dq;

  // Lines that neither end drives read low, like a weak pull-down.
  assign dq = dq_dev_oe ? dq_dev_o : (dq_ctl_oe ? dq_ctl_o : '0);

  modport dev (
    input  cs_n,
    input  ras_n,
    input  cas_n,
    input  we_n,
    input  ba,
    input  addr,
    input  dqm,
    input  dq,
    output dq_dev_o,
    output dq_dev_oe
  );
  modport ctl (
    output cs_n,
    output ras_n,
    output cas_n,
    output we_n,
    output ba,
    output addr,
    output dqm,
    output dq_ctl_o,
    output dq_ctl_oe,
    input  dq
  );
endinterface

// file: rtl/sdb_pkg.sv
// Constants shared by both ends of the burst data path.
// Assumes one clock, clk_sys, shared by controller and memory.
// Operation
// - Read data appears after programmed read latency.
// - Data lines float when read burst ends.
// - Page bursts run until stopped, wrap column.
// - Chained READ issued latency minus one early.
// - READ accepted on any cycle after READ.
// - Idle cycle between read data and WRITE.
// - Output mask latency two; mask before WRITE.
// - Registered WRITE floats data lines regardless.
// - Input mask acts immediately on write data.
// - PRECHARGE ends read latency minus one early.
// - Wait precharge recovery before same bank.
// - BURST TERMINATE ends read latency minus one early.
// - Auto precharge chosen per command, after burst.
// - First write element taken on WRITE edge.
// - Finished write burst ignores further input.
// - New WRITE any cycle, data goes with it.
// - READ after write ignores input from then.
// - PRECHARGE after write recovery time elapses.
// - Auto precharge allows write recovery, one clock.
// - Fast clocks mask data around write PRECHARGE.
// - Read latency selectable two or three.
package sdb_pkg;
  localparam int DATA_W   = 16;
  localparam int COL_W    = 9;
  localparam int BANK_W   = 2;
  localparam int ADDR_W   = 12;
  localparam int AP_BIT   = 10;
  // Command codes on {ras_n, cas_n, we_n}.
  localparam logic [2:0] CMD_NOP   = 3'h7;
  localparam logic [2:0] CMD_READ  = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_BST   = 3'h6;
  localparam logic [2:0] CMD_PRE   = 3'h2;
  // Burst length codes.
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  // Timing.
  localparam int CLK_NS                 = 100;
  localparam int WRITE_RECOVERY_NS      = 15;
  localparam int PRECHARGE_RECOVERY_NS  = 20;
  localparam int WR_RAW  = (WRITE_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC  = (WR_RAW < 1) ? 1 : WR_RAW;
  localparam int RP_RAW  = (PRECHARGE_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRP_CYC = (RP_RAW < 1) ? 1 : RP_RAW;
  // Controller register map, byte addresses.
  localparam logic [4:0] REG_CMD    = 5'h00;
  localparam logic [4:0] REG_CFG    = 5'h04;
  localparam logic [4:0] REG_WDATA  = 5'h08;
  localparam logic [4:0] REG_RDATA  = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  // REG_CMD fields.
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_BANK_LSB = 2;
  localparam int CMD_COL_LSB  = 4;
  localparam int CMD_AP_POS   = 16;
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_PRE   = 2'h2;
  localparam logic [1:0] OP_BST   = 2'h3;
  // REG_CFG fields and reset value: latency two, burst of four.
  localparam int CFG_CL3_POS = 0;
  localparam int CFG_BL_LSB  = 1;
  localparam logic [3:0] CFG_RESET = 4'h4;

  // Mask of the column bits that advance inside a burst.
  function automatic logic [ADDR_W-1:0] burst_mask(input logic [2:0] bl);
    case (bl)
      BL_1:    burst_mask = 12'h000;
      BL_2:    burst_mask = 12'h001;
      BL_4:    burst_mask = 12'h003;
      BL_8:    burst_mask = 12'h007;
      default: burst_mask = 12'hfff;
    endcase
  endfunction
endpackage
